// >>> inc/sarr_pkg.sv
// Constants, register map and types of the attribute read responder
package sarr_pkg;
	// Register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] OFS_SUBCMD   = 8'h00;
	localparam logic [7:0] OFS_COUNT    = 8'h04;
	localparam logic [7:0] OFS_SECTOR   = 8'h08;
	localparam logic [7:0] OFS_TRACK    = 8'h0c;
	localparam logic [7:0] OFS_HEAD     = 8'h10;
	localparam logic [7:0] OFS_DRIVE    = 8'h14;
	localparam logic [7:0] OFS_COMMAND  = 8'h18;
	localparam logic [7:0] OFS_ERROR    = 8'h1c;
	localparam logic [7:0] OFS_DATA     = 8'h20;
	localparam logic [7:0] OFS_ATTR_SEL = 8'h24;
	localparam logic [7:0] OFS_ATTR_ID  = 8'h28;
	localparam logic [7:0] OFS_ATTR_VAL = 8'h2c;
	localparam logic [7:0] OFS_RAW_LO   = 8'h30;
	localparam logic [7:0] OFS_RAW_HI   = 8'h34;
	localparam logic [7:0] OFS_OFFLINE  = 8'h38;
	localparam logic [7:0] OFS_TIMES    = 8'h3c;
	// Command decode
	localparam logic [7:0]  CMD_SMART  = 8'hb0;
	localparam logic [7:0]  SUB_RDATTR = 8'hd0;
	localparam logic [15:0] TRACK_KEY  = 16'hc24f;
	// Structure layout in 16-bit word indices
	localparam logic [8:0]  WORDS       = 9'h100;
	localparam logic [8:0]  W_REV       = 9'h000;
	localparam logic [8:0]  W_ENT_FIRST = 9'h001;
	localparam logic [8:0]  W_ENT_LAST  = 9'h0b4;
	localparam logic [8:0]  W_OFF_STAT  = 9'h0b5;
	localparam logic [8:0]  W_TOTAL     = 9'h0b6;
	localparam logic [8:0]  W_OFFCAP    = 9'h0b7;
	localparam logic [8:0]  W_SMCAP     = 9'h0b8;
	localparam logic [8:0]  W_ERRLOG    = 9'h0b9;
	localparam logic [8:0]  W_POLL      = 9'h0ba;
	localparam logic [8:0]  W_LAST      = 9'h0ff;
	localparam logic [2:0]  WOFF_LAST   = 3'h5;
	localparam logic [4:0]  ENT_LAST    = 5'h1d;
	localparam int          N_ENT       = 30;
	// Fixed structure content
	localparam logic [15:0] REV_NUM     = 16'h0010;
	localparam logic [7:0]  OFFCAP      = 8'h5b;
	localparam logic [15:0] SMCAP       = 16'h0003;
	localparam logic [7:0]  ERRLOG      = 8'h01;
	localparam logic [15:0] FLAG_MASK   = 16'h003f;
	localparam logic [7:0]  ID_CRC      = 8'hc7;
	localparam logic [7:0]  VAL_INIT    = 8'h64;
	localparam logic [7:0]  VAL_INIT_CRC = 8'hc8;
	localparam logic [7:0]  VAL_MIN     = 8'h01;
	localparam logic [7:0]  VAL_MAX     = 8'hfd;
	localparam logic [47:0] RAW_SAT     = 48'h0000_000f_ffff;
	// Reset values and responses
	localparam logic [7:0]  RST_BYTE    = 8'h00;
	localparam logic [15:0] RST_HALF    = 16'h0000;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	// FIFO shape
	localparam int          FIFO_W      = 16;
	localparam int          FIFO_D      = 8;
	// Control states, Gray coded along idle, fill, transfer
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_FILL = 2'h1,
		ST_XFER = 2'h3
	} sarr_state_t;
endpackage : sarr_pkg

// >>> logic/sarr_top.sv
// Attribute read responder: AXI4-Lite task file, structure builder, FIFO
// Summary of operation
// [R1] Subcommand D0h with track C24Fh returns exactly 512 bytes of attribute data.
// [R2] Accept: raise busy, fill buffer, then data request, drop busy, interrupt.
// [R3] Revision in bytes 0-1, thirty entries 2-361, status bytes 362 and 363.
// [R4] Total time 364-365, 366 reserved, capabilities 367-369, 374-510 reserved zero.
// [R5] Short poll time byte 372, extended byte 373, failure checkpoint byte 371.
// [R6] Error logging byte 370 reads 01h; upper bits reserved zero.
// [R7] Revision number is the fixed value 0010h.
// [R8] Each entry is 12 bytes; first byte is the attribute identifier.
// [R9] Flag bit 0 selects pre-failure versus advisory meaning.
// [R10] Flag bit 1 selects on-line versus off-line-only update.
// [R11] Flag bits 2-5 classify the attribute; bits 6-15 read zero.
// [R12] Normalized value 01h-FDh, initial 64h; 00h, FEh, FFh mean unused.
// [R13] Identifier 199 starts its normalized value at C8h.
// [R14] Worst byte keeps the lowest valid normalized value ever written.
// [R15] Raw six bytes saturate at FFFFFh; entry byte 11 reads 00h.
// [R16] Byte 511 carries a checksum over the first 511 bytes.
// [R17] Checksum makes all 512 bytes sum to zero modulo 256.
// [R18] Host reads all 256 words before issuing another command.
// [R19] Drive, head and sector registers stay unchanged by the command.
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps

// Synchronous FIFO with occupancy counter
module sarr_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic             clock,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output      logic             in_ready,
	output      logic [WIDTH-1:0] out_data,
	output      logic             out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] PLAST = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wp_ff;
	logic [AW-1:0]    rp_ff;
	logic [AW:0]      cnt_ff;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_ff != FULL);
	assign out_valid = (cnt_ff != '0);
	assign out_data  = mem_ff[rp_ff];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Storage write, no reset needed on data
	always_ff @(posedge clock)
	begin
		if (push)
			mem_ff[wp_ff] <= in_data;
	end

	// Pointers wrap at the depth so any depth works
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wp_ff  <= '0;
			rp_ff  <= '0;
			cnt_ff <= '0;
		end
		else
		begin
			if (push)
				wp_ff <= (wp_ff == PLAST) ? '0 : wp_ff + 1'b1;
			if (pop)
				rp_ff <= (rp_ff == PLAST) ? '0 : rp_ff + 1'b1;
			if (push && !pop)
				cnt_ff <= cnt_ff + 1'b1;
			else if (pop && !push)
				cnt_ff <= cnt_ff - 1'b1;
		end
	end
endmodule : sarr_fifo

module sarr_top
	import sarr_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output      logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output      logic        s_axi_wready,
	output      logic [1:0]  s_axi_bresp,
	output      logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output      logic        s_axi_arready,
	output      logic [31:0] s_axi_rdata,
	output      logic [1:0]  s_axi_rresp,
	output      logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output      logic        host_intrq
);
	sarr_state_t state_ff;
	logic        aw_rdy_ff, b_vld_ff, ar_rdy_ff, r_vld_ff;
	logic [1:0]  b_resp_ff, r_resp_ff;
	logic [31:0] r_data_ff;
	logic [7:0]  subcmd_ff, count_ff, sector_ff, head_ff, drive_ff;
	logic [15:0] track_ff;
	logic        bsy_ff, drq_ff, err_ff, intrq_ff;
	logic [4:0]  sel_ff;
	logic [7:0]  offline_ff, selftest_ff, chkpt_ff, short_ff, ext_ff;
	logic [15:0] total_ff;
	logic [7:0]  id_ff [N_ENT];
	logic [15:0] flags_ff [N_ENT];
	logic [7:0]  val_ff [N_ENT];
	logic [7:0]  worst_ff [N_ENT];
	logic [47:0] raw_ff [N_ENT];
	logic [8:0]  gen_ff;
	logic [4:0]  ent_ff;
	logic [2:0]  woff_ff;
	logic [7:0]  chk_ff;
	logic [15:0] gen_word, f_data;
	logic        f_in_rdy, f_out_vld, pop, push;
	logic        wr_take, rd_take, cmd_wr, cmd_ok;
	logic [31:0] wr_val;

	// Byte-lane merge so partial writes keep untouched bytes
	function automatic logic [31:0] sarr_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (st[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction : sarr_merge

	// Known offsets; anything else answers SLVERR
	function automatic logic sarr_known(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= OFS_TIMES);
	endfunction : sarr_known

	// Current register contents as software sees them
	function automatic logic [31:0] sarr_view(input logic [7:0] a);
		logic [31:0] v;
		v = '0;
		if (a == OFS_SUBCMD)        v = {24'h00_0000, subcmd_ff};
		else if (a == OFS_COUNT)    v = {24'h00_0000, count_ff};
		else if (a == OFS_SECTOR)   v = {24'h00_0000, sector_ff};
		else if (a == OFS_TRACK)    v = {16'h0000, track_ff};
		else if (a == OFS_HEAD)     v = {24'h00_0000, head_ff};
		else if (a == OFS_DRIVE)    v = {24'h00_0000, drive_ff};
		else if (a == OFS_COMMAND)
			v = {24'h00_0000, bsy_ff, !bsy_ff, 2'h0, drq_ff, 2'h0, err_ff};
		else if (a == OFS_ERROR)    v = {24'h00_0000, 5'h00, err_ff, 2'h0};
		else if (a == OFS_DATA)
			v = (drq_ff && f_out_vld) ? {16'h0000, f_data} : '0;
		else if (a == OFS_ATTR_SEL) v = {27'h000_0000, sel_ff};
		else if (a == OFS_ATTR_ID)  v = {8'h00, flags_ff[sel_ff], id_ff[sel_ff]};
		else if (a == OFS_ATTR_VAL) v = {16'h0000, worst_ff[sel_ff], val_ff[sel_ff]};
		else if (a == OFS_RAW_LO)   v = raw_ff[sel_ff][31:0];
		else if (a == OFS_RAW_HI)   v = {16'h0000, raw_ff[sel_ff][47:32]};
		else if (a == OFS_OFFLINE)  v = {8'h00, chkpt_ff, selftest_ff, offline_ff};
		else if (a == OFS_TIMES)    v = {ext_ff, short_ff, total_ff};
		return v;
	endfunction : sarr_view

	assign s_axi_awready = aw_rdy_ff;
	assign s_axi_wready  = aw_rdy_ff;
	assign s_axi_bvalid  = b_vld_ff;
	assign s_axi_bresp   = b_resp_ff;
	assign s_axi_arready = ar_rdy_ff;
	assign s_axi_rvalid  = r_vld_ff;
	assign s_axi_rdata   = r_data_ff;
	assign s_axi_rresp   = r_resp_ff;
	assign host_intrq    = intrq_ff;

	// Address and data are taken together, which keeps the decode simple
	assign wr_take = aw_rdy_ff & s_axi_awvalid & s_axi_wvalid;
	assign rd_take = ar_rdy_ff & s_axi_arvalid;
	assign wr_val  = sarr_merge(sarr_view(s_axi_awaddr), s_axi_wdata, s_axi_wstrb);
	assign cmd_wr  = wr_take && (s_axi_awaddr == OFS_COMMAND) && s_axi_wstrb[0];
	assign cmd_ok  = (s_axi_wdata[7:0] == CMD_SMART) && (subcmd_ff == SUB_RDATTR)
		&& (track_ff == TRACK_KEY); // [R1]
	assign pop     = rd_take && (s_axi_araddr == OFS_DATA) && drq_ff && f_out_vld;
	assign push    = (state_ff != ST_IDLE) && (gen_ff < WORDS) && f_in_rdy;

	// Write channel: one write in flight, response after the take
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			aw_rdy_ff <= 1'b0;
			b_vld_ff  <= 1'b0;
			b_resp_ff <= RESP_OKAY;
		end
		else
		begin
			aw_rdy_ff <= s_axi_awvalid & s_axi_wvalid & !aw_rdy_ff & !b_vld_ff;
			if (wr_take)
			begin
				b_vld_ff  <= 1'b1;
				b_resp_ff <= sarr_known(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				b_vld_ff <= 1'b0;
		end
	end

	// Read channel: data is sampled at the address take
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ar_rdy_ff <= 1'b0;
			r_vld_ff  <= 1'b0;
			r_data_ff <= '0;
			r_resp_ff <= RESP_OKAY;
		end
		else
		begin
			ar_rdy_ff <= s_axi_arvalid & !ar_rdy_ff & !r_vld_ff;
			if (rd_take)
			begin
				r_vld_ff  <= 1'b1;
				r_data_ff <= sarr_view(s_axi_araddr);
				r_resp_ff <= sarr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_rready)
				r_vld_ff <= 1'b0;
		end
	end

	// Task file and drive status sources; the command never writes them
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			subcmd_ff <= RST_BYTE;
			count_ff <= RST_BYTE;
			sector_ff <= RST_BYTE;
			head_ff <= RST_BYTE;
			drive_ff <= RST_BYTE;
			track_ff <= RST_HALF;
			sel_ff <= '0;
			offline_ff <= RST_BYTE;
			selftest_ff <= RST_BYTE;
			chkpt_ff <= RST_BYTE;
			total_ff <= RST_HALF;
			short_ff <= RST_BYTE;
			ext_ff <= RST_BYTE;
		end
		else if (wr_take)
		begin
			// Host writes only; completion leaves these alone [R19]
			if (s_axi_awaddr == OFS_SUBCMD) subcmd_ff <= wr_val[7:0];
			else if (s_axi_awaddr == OFS_COUNT) count_ff <= wr_val[7:0];
			else if (s_axi_awaddr == OFS_SECTOR) sector_ff <= wr_val[7:0];
			else if (s_axi_awaddr == OFS_TRACK) track_ff <= wr_val[15:0];
			else if (s_axi_awaddr == OFS_HEAD) head_ff <= wr_val[7:0];
			else if (s_axi_awaddr == OFS_DRIVE) drive_ff <= wr_val[7:0];
			else if (s_axi_awaddr == OFS_ATTR_SEL && wr_val[4:0] <= ENT_LAST)
				sel_ff <= wr_val[4:0];
			else if (s_axi_awaddr == OFS_OFFLINE)
			begin
				offline_ff <= wr_val[7:0]; // [R3]
				selftest_ff <= wr_val[15:8];
				chkpt_ff <= wr_val[23:16]; // [R5]
			end
			else if (s_axi_awaddr == OFS_TIMES)
			begin
				total_ff <= wr_val[15:0]; // [R4]
				short_ff <= wr_val[23:16]; // [R5]
				ext_ff <= wr_val[31:24];
			end
		end
	end

	// Per-entry attribute storage, written through the selected index
	for (genvar i = 0; i < N_ENT; i++)
	begin : g_ent
		logic        hit;
		logic [47:0] raw_new;
		assign hit = wr_take && (sel_ff == 5'(i));
		assign raw_new = (s_axi_awaddr == OFS_RAW_LO)
			? {raw_ff[i][47:32], wr_val} : {wr_val[15:0], raw_ff[i][31:0]};
		always_ff @(posedge clock or posedge sys_rst)
		begin
			if (sys_rst)
			begin
				id_ff[i] <= RST_BYTE;
				flags_ff[i] <= RST_HALF;
				val_ff[i] <= RST_BYTE;
				worst_ff[i] <= RST_BYTE;
				raw_ff[i] <= '0;
			end
			else if (hit && s_axi_awaddr == OFS_ATTR_ID)
			begin
				id_ff[i] <= wr_val[7:0]; // [R8]
				// Reserved flag bits forced to zero [R9] [R10] [R11]
				flags_ff[i] <= wr_val[23:8] & FLAG_MASK;
				// New identifier starts at its initial value [R12] [R13]
				val_ff[i] <= (wr_val[7:0] == ID_CRC) ? VAL_INIT_CRC : VAL_INIT;
				worst_ff[i] <= (wr_val[7:0] == ID_CRC) ? VAL_INIT_CRC : VAL_INIT;
			end
			else if (hit && s_axi_awaddr == OFS_ATTR_VAL)
			begin
				val_ff[i] <= wr_val[7:0]; // [R12]
				// Only in-use values can lower the worst mark [R14]
				if (wr_val[7:0] >= VAL_MIN && wr_val[7:0] <= VAL_MAX
					&& wr_val[7:0] < worst_ff[i])
					worst_ff[i] <= wr_val[7:0];
			end
			else if (hit && (s_axi_awaddr == OFS_RAW_LO || s_axi_awaddr == OFS_RAW_HI))
				raw_ff[i] <= (raw_new > RAW_SAT) ? RAW_SAT : raw_new; // [R15]
		end
	end

	// Word mux of the structure, two bytes little endian per word
	always_comb
	begin
		gen_word = 16'h0000;
		if (gen_ff == W_REV)
			gen_word = REV_NUM; // [R7]
		else if (gen_ff <= W_ENT_LAST)
		begin
			// Twelve-byte entry, six words [R3] [R8]
			case (woff_ff)
				3'h0: gen_word = {flags_ff[ent_ff][7:0], id_ff[ent_ff]};
				3'h1: gen_word = {val_ff[ent_ff], flags_ff[ent_ff][15:8]};
				3'h2: gen_word = {raw_ff[ent_ff][7:0], worst_ff[ent_ff]};
				3'h3: gen_word = raw_ff[ent_ff][23:8];
				3'h4: gen_word = raw_ff[ent_ff][39:24];
				default: gen_word = {8'h00, raw_ff[ent_ff][47:40]}; // [R15]
			endcase
		end
		else if (gen_ff == W_OFF_STAT) gen_word = {selftest_ff, offline_ff}; // [R3]
		else if (gen_ff == W_TOTAL)    gen_word = total_ff; // [R4]
		else if (gen_ff == W_OFFCAP)   gen_word = {OFFCAP, 8'h00};
		else if (gen_ff == W_SMCAP)    gen_word = SMCAP;
		else if (gen_ff == W_ERRLOG)   gen_word = {chkpt_ff, ERRLOG}; // [R6]
		else if (gen_ff == W_POLL)     gen_word = {ext_ff, short_ff}; // [R5]
		else if (gen_ff == W_LAST)     gen_word = {8'h00 - chk_ff, 8'h00}; // [R16] [R17]
	end

	// Builder walks all 256 words; the FIFO stalls it when the host lags
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			gen_ff <= WORDS;
			ent_ff <= '0;
			woff_ff <= '0;
			chk_ff <= RST_BYTE;
		end
		else if (cmd_wr && cmd_ok && state_ff == ST_IDLE)
		begin
			gen_ff <= '0;
			ent_ff <= '0;
			woff_ff <= '0;
			chk_ff <= RST_BYTE;
		end
		else if (push)
		begin
			gen_ff <= gen_ff + 1'b1; // [R1]
			chk_ff <= chk_ff + gen_word[7:0] + gen_word[15:8]; // [R17]
			if (gen_ff >= W_ENT_FIRST && gen_ff <= W_ENT_LAST)
			begin
				woff_ff <= (woff_ff == WOFF_LAST) ? '0 : woff_ff + 1'b1;
				if (woff_ff == WOFF_LAST)
					ent_ff <= ent_ff + 1'b1;
			end
		end
	end

	sarr_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_D)
	) u_fifo (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.in_data   (gen_word),
		.in_valid  (push),
		.in_ready  (f_in_rdy),
		.out_data  (f_data),
		.out_valid (f_out_vld),
		.out_ready (pop)
	);

	// Command handshake; a new interrupt beats a status read that clears it
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_ff <= ST_IDLE;
			bsy_ff <= 1'b0;
			drq_ff <= 1'b0;
			err_ff <= 1'b0;
			intrq_ff <= 1'b0;
		end
		else
		begin
			if (rd_take && s_axi_araddr == OFS_COMMAND)
				intrq_ff <= 1'b0;
			case (state_ff)
				ST_IDLE:
					if (cmd_wr && cmd_ok)
					begin
						state_ff <= ST_FILL;
						bsy_ff <= 1'b1; // [R2]
						err_ff <= 1'b0;
					end
					else if (cmd_wr)
					begin
						err_ff <= 1'b1; // Unsupported command aborts
						intrq_ff <= 1'b1;
					end
				ST_FILL:
					if (!f_in_rdy || gen_ff == WORDS)
					begin
						state_ff <= ST_XFER;
						bsy_ff <= 1'b0; // [R2]
						drq_ff <= 1'b1;
						intrq_ff <= 1'b1;
					end
				default:
					// Host drains every word before the next command [R18]
					if (gen_ff == WORDS && !f_out_vld)
					begin
						state_ff <= ST_IDLE;
						drq_ff <= 1'b0;
					end
			endcase
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	a_start_busy: assert property (cmd_wr && cmd_ok && state_ff == ST_IDLE
		|=> bsy_ff && !drq_ff && state_ff == ST_FILL) // [R2]
		else $error("busy not raised on accepted command");
	a_drq_soon: assert property ($rose(bsy_ff) |-> ##[1:12] drq_ff && !bsy_ff) // [R2]
		else $error("data request not raised after fill");
	a_drq_intr: assert property ($rose(drq_ff) |-> intrq_ff && !bsy_ff) // [R2]
		else $error("data request without interrupt");
	a_full_count: assert property (state_ff == ST_XFER ##1 state_ff == ST_IDLE
		|-> gen_ff == WORDS && !f_out_vld) // [R1]
		else $error("transfer ended before 256 words");
	a_rev_word: assert property (push && gen_ff == W_REV
		|-> gen_word == 16'h0010) // [R7]
		else $error("revision word wrong");
	a_errlog_byte: assert property (push && gen_ff == W_ERRLOG
		|-> gen_word[7:0] == 8'h01) // [R6]
		else $error("error logging byte wrong");
	a_tail_zero: assert property (push && gen_ff > W_POLL && gen_ff < W_LAST
		|-> gen_word == 16'h0000) // [R4]
		else $error("reserved tail not zero");
	a_entry_pad: assert property (push && gen_ff >= W_ENT_FIRST
		&& gen_ff <= W_ENT_LAST && woff_ff == 3'h5 |-> gen_word[15:8] == 8'h00) // [R15]
		else $error("entry byte 11 not zero");
	a_chk_zero: assert property (push && gen_ff == W_LAST
		|-> 8'(chk_ff + gen_word[15:8]) == 8'h00) // [R17]
		else $error("checksum does not close to zero");
	a_init_crc: assert property (wr_take && s_axi_awaddr == OFS_ATTR_ID
		&& wr_val[7:0] == ID_CRC |=> val_ff[sel_ff] == 8'hc8) // [R13]
		else $error("identifier 199 initial value wrong");
	a_raw_sat: assert property (raw_ff[sel_ff] <= 48'h0000_000f_ffff) // [R15]
		else $error("raw value above saturation");

	c_accept: cover property (cmd_wr && cmd_ok && state_ff == ST_IDLE);
	c_abort: cover property (cmd_wr && !cmd_ok && state_ff == ST_IDLE);
	c_finish: cover property (state_ff == ST_XFER ##1 state_ff == ST_IDLE);
endmodule : sarr_top

// >>> test/sarr_host_model.sv
// Host side AXI4-Lite master model that runs one register request at a time
`timescale 1ns/1ps
module sarr_host_model (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        req_go,
	input  wire logic        req_wr,
	input  wire logic [7:0]  req_addr,
	input  wire logic [31:0] req_data,
	output      logic        req_done,
	output      logic [31:0] rsp_data,
	output      logic [1:0]  rsp_resp,
	output      logic [7:0]  s_axi_awaddr,
	output      logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output      logic [31:0] s_axi_wdata,
	output      logic [3:0]  s_axi_wstrb,
	output      logic        s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output      logic        s_axi_bready,
	output      logic [7:0]  s_axi_araddr,
	output      logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output      logic        s_axi_rready
);
	// Channels drop valid only on their own handshake; released addresses and write data are inverted
	// so that a slave sampling late sees a wrong value instead of a stale right one
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} <= '0;
			{s_axi_araddr, s_axi_arvalid, s_axi_rready, req_done} <= '0;
			{rsp_data, rsp_resp, s_axi_wstrb} <= '0;
		end
		else
		begin
			req_done <= 1'b0;
			if (req_go && req_wr)
			begin
				s_axi_awaddr  <= req_addr;
				s_axi_wdata   <= req_data;
				s_axi_wstrb   <= 4'hf;
				s_axi_awvalid <= 1'b1;
				s_axi_wvalid  <= 1'b1;
				s_axi_bready  <= 1'b1;
			end
			if (req_go && !req_wr)
			begin
				s_axi_araddr  <= req_addr;
				s_axi_arvalid <= 1'b1;
				s_axi_rready  <= 1'b1;
			end
			if (s_axi_awvalid && s_axi_awready)
			begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr  <= ~s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata  <= ~s_axi_wdata;
			end
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr  <= ~s_axi_araddr;
			end
			if (s_axi_bready && s_axi_bvalid)
			begin
				s_axi_bready <= 1'b0;
				rsp_resp     <= s_axi_bresp;
				req_done     <= 1'b1;
			end
			if (s_axi_rready && s_axi_rvalid)
			begin
				s_axi_rready <= 1'b0;
				rsp_data     <= s_axi_rdata;
				rsp_resp     <= s_axi_rresp;
				req_done     <= 1'b1;
			end
		end
	end
endmodule : sarr_host_model

// >>> test/test_smart_attribute_read_responder.sv
// Self-checking bench of the attribute read responder
`timescale 1ns/1ps
module test_smart_attribute_read_responder
	import sarr_pkg::*;
;
	localparam logic [7:0] TF[3] = '{OFS_SECTOR, OFS_HEAD, OFS_DRIVE};
	logic        clock, sys_rst, req_go, req_wr, req_done, host_intrq;
	logic [7:0]  req_addr, s_axi_awaddr, s_axi_araddr, v, sum;
	logic [31:0] req_data, rsp_data, s_axi_wdata, s_axi_rdata, q, r38, r3c, rv;
	logic [1:0]  rsp_resp, s_axi_bresp, s_axi_rresp, r;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]  a_id[30], a_val[30], a_wst[30], rg[3];
	logic [15:0] a_flg[30];
	logic [47:0] a_raw[30];
	int          num_errors, cmp_count, seed, n;

	sarr_host_model u_host (.clock, .sys_rst, .req_go, .req_wr, .req_addr, .req_data,
		.req_done, .rsp_data, .rsp_resp, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	sarr_top u_dut (.clock, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .host_intrq);

	// Free running 50 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// Expected structure word, worked out from the bench's own copy of the registers
	function automatic logic [15:0] exp_word(input int w);
		int          e, i;
		logic [7:0]  s;
		logic [15:0] t;
		e = (w - 1) / 6;
		s = 8'h00;
		if (w == 0) return REV_NUM;
		if (w <= 180)
		begin
			case ((w - 1) % 6)
				0: return {a_flg[e][7:0], a_id[e]};
				1: return {a_val[e], a_flg[e][15:8]};
				2: return {a_raw[e][7:0], a_wst[e]};
				3: return a_raw[e][23:8];
				4: return a_raw[e][39:24];
				default: return {8'h00, a_raw[e][47:40]};
			endcase
		end
		case (w)
			181: return r38[15:0];
			182: return r3c[15:0];
			183: return {OFFCAP, 8'h00};
			184: return SMCAP;
			185: return {r38[23:16], ERRLOG};
			186: return r3c[31:16];
			default: ;
		endcase
		if (w != 255) return 16'h0000;
		for (i = 0; i < 255; i++)
		begin
			t = exp_word(i);
			s = s + t[7:0] + t[15:8];
		end
		return {8'h00 - s, 8'h00};
	endfunction : exp_word

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic final_report;
		$display("Compares %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report

	// One register access through the host model; the answer lands in q and r
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		req_wr   <= w;
		req_addr <= a;
		req_data <= d;
		req_go   <= 1'b1;
		@(posedge clock);
		req_go <= 1'b0;
		for (n = 0; n < 200 && req_done !== 1'b1; n++) @(posedge clock);
		if (n == 200)
		begin
			num_errors++;
			final_report();
		end
		q = rsp_data;
		r = rsp_resp;
	endtask : bus

	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0000_0000);
	endtask : rd

	// Interrupt must come within a bounded time
	task automatic wait_irq;
		for (n = 0; n < 400 && host_intrq !== 1'b1; n++) @(posedge clock);
		if (n == 400)
		begin
			num_errors++;
			final_report();
		end
	endtask : wait_irq

	initial
	begin
		{sys_rst, req_go, req_wr, req_addr, req_data} = {1'b1, 42'h0};
		num_errors = 0;
		cmp_count  = 0;
		seed       = 97143;
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		rd(OFS_COMMAND);
		chk(q, 32'h0000_0040);
		chk({31'h0, host_intrq}, 32'h0000_0000);
		// Unmapped and unaligned places answer with an error
		rd(8'h40);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		chk(q, 32'h0000_0000);
		bus(1'b1, 8'h06, $random(seed));
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		$display("Reset and address decode test done");
		// Task-file registers that the command must leave alone
		for (int i = 0; i < 3; i++)
		begin
			rg[i] = 8'($random(seed));
			bus(1'b1, TF[i], {24'h0, rg[i]});
		end
		// Attribute table; entry 5 is the CRC count and entry 29 stays unused
		for (int e = 0; e < 30; e++)
		begin
			a_id[e]  = (e == 5) ? ID_CRC : ((e == 29) ? 8'h00 : 8'($random(seed) | 1));
			a_flg[e] = 16'($random(seed));
			bus(1'b1, OFS_ATTR_SEL, e);
			bus(1'b1, OFS_ATTR_ID, {8'h00, a_flg[e], a_id[e]});
			a_flg[e] = a_flg[e] & FLAG_MASK;
			a_val[e] = (a_id[e] == ID_CRC) ? VAL_INIT_CRC : VAL_INIT;
			a_wst[e] = a_val[e];
			if (e % 3 != 0)
			begin
				v = (e == 4) ? 8'hfe : 8'($random(seed) | 1);
				bus(1'b1, OFS_ATTR_VAL, {24'h0, v});
				a_val[e] = v;
				if (v >= VAL_MIN && v <= VAL_MAX && v < a_wst[e]) a_wst[e] = v;
			end
			rv = (e % 2) ? $random(seed) : ($random(seed) & 32'h000f_ffff);
			bus(1'b1, OFS_RAW_HI, 32'h0000_0000);
			bus(1'b1, OFS_RAW_LO, rv);
			a_raw[e] = (rv > 32'h000f_ffff) ? RAW_SAT : {16'h0, rv};
		end
		r38 = $random(seed) & 32'h00ff_ffff;
		r3c = $random(seed);
		bus(1'b1, OFS_OFFLINE, r38);
		bus(1'b1, OFS_TIMES, r3c);
		// An unknown command is aborted with an interrupt
		bus(1'b1, OFS_SUBCMD, {24'h0, SUB_RDATTR});
		bus(1'b1, OFS_TRACK, {16'h0, TRACK_KEY});
		bus(1'b1, OFS_COMMAND, 32'h0000_00ec);
		wait_irq();
		rd(OFS_ERROR);
		chk(q & 32'h0000_0004, 32'h0000_0004);
		rd(OFS_COMMAND);
		chk(q & 32'h0000_00c9, 32'h0000_0041);
		chk({31'h0, host_intrq}, 32'h0000_0000);
		$display("Abort test done");
		// Read the structure with a slow host so the FIFO sits full
		bus(1'b1, OFS_COMMAND, {24'h0, CMD_SMART});
		wait_irq();
		rd(OFS_COMMAND);
		chk(q & 32'h0000_00c8, 32'h0000_0048);
		chk({31'h0, host_intrq}, 32'h0000_0000);
		sum = 8'h00;
		for (int w = 0; w < 256; w++)
		begin
			repeat ($random(seed) & 3) @(posedge clock);
			rd(OFS_DATA);
			chk(q, {16'h0, exp_word(w)});
			sum = sum + q[7:0] + q[15:8];
		end
		chk({24'h0, sum}, 32'h0000_0000);
		rd(OFS_DATA);
		chk(q, 32'h0000_0000);
		rd(OFS_COMMAND);
		chk(q & 32'h0000_00c8, 32'h0000_0040);
		for (int i = 0; i < 3; i++)
		begin
			rd(TF[i]);
			chk(q, {24'h0, rg[i]});
		end
		$display("Attribute read test done");
		final_report();
	end
endmodule : test_smart_attribute_read_responder
